// [rtl/fpnro_pkg.sv]
// Constants and types shared by the flash protection and overlay block.
//
// Behaviour
// - Software protection ignores program-go and erase-go; no program or erase mode.
// - Emulation lock protects all blocks from program and erase; verify still works.
// - Block select gives erase protection only; programming and verify stay allowed.
// - Block select of all zeros leaves every block erase-protected.
// - Overlay RAM stays writable while emulation lock protects the flash.
// - A malfunction during program or erase sets the fault flag to one.
// - Fault keeps control and block select values but aborts the operation at once.
// - With fault set, go bits start nothing; verify bits still enter verify mode.
// - Only external reset pin, watchdog reset or hardware standby clear the fault.
// - Registers stay writable under fault; software standby initialises both.
// - Only the defined fault conditions raise the fault flag.
// - Either go bit set blocks the non-maskable interrupt.
// - Boot mode blocks the non-maskable interrupt until the branch into RAM.
// - Fault, and go bits held during RAM emulation, also block the interrupt.
// - Interrupt blocking applies only in on-board programming mode.
// - After the boot branch the interrupt passes except while a go bit is held or the fault flag is set.
// - A RAM window overlays a small flash block chosen by a three-bit field.
// - Overlaid flash addresses and the original RAM window reach the same RAM.
// - Target two maps the window onto the third small block's range.
// - Blocking lifts on cleared go bits, standby, pin low or software enable zero.
// - Any reset and standby initialise control and block select; flash protected.
package fpnro_pkg;

    // ==========================================================
    // Register offsets (byte addresses on the register bus).
    localparam logic [4:0] FPNRO_OFS_CTRL = 5'h00;
    localparam logic [4:0] FPNRO_OFS_BSEL = 5'h04;
    localparam logic [4:0] FPNRO_OFS_OVL = 5'h08;
    localparam logic [4:0] FPNRO_OFS_STAT = 5'h0c;

    // ==========================================================
    // Field positions.
    localparam int FPNRO_CTRL_PGO = 0;
    localparam int FPNRO_CTRL_EGO = 1;
    localparam int FPNRO_CTRL_PVER = 2;
    localparam int FPNRO_CTRL_EVER = 3;
    localparam int FPNRO_CTRL_SWEN = 4;
    localparam int FPNRO_OVL_LOCK = 0;
    localparam int FPNRO_OVL_TGT_LSB = 1;
    localparam int FPNRO_STAT_FAULT = 7;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] FPNRO_CTRL_RST = 8'h00;
    localparam logic [7:0] FPNRO_BSEL_RST = 8'h00;
    localparam logic [7:0] FPNRO_OVL_RST = 8'h00;

    // ==========================================================
    // Overlay window geometry.
    localparam logic [19:0] FPNRO_RAM_BASE = 20'hff800;
    localparam int FPNRO_WIN_BITS = 10;

    // ==========================================================
    // Flash operating modes, one-hot.
    typedef enum logic [4:0] {
        FPNRO_IDLE = 5'b00001,
        FPNRO_PROG = 5'b00010,
        FPNRO_ERASE = 5'b00100,
        FPNRO_PVERIFY = 5'b01000,
        FPNRO_EVERIFY = 5'b10000
    } fpnro_mode_t;

endpackage : fpnro_pkg

// [rtl/fpnro_ovl_if.sv]
// Interface carrying the overlay decode request and result.
`timescale 1ns/10ps
interface fpnro_ovl_if;
    logic [19:0] cpuAddr;
    logic ovlEnable;
    logic [2:0] ovlTarget;
    logic ramHit;
    logic [9:0] ramIndex;

    // The control side supplies the address and overlay setting.
    modport ctrl (output cpuAddr, output ovlEnable, output ovlTarget,
        input ramHit, input ramIndex);
    // The decoder returns the RAM hit and word index.
    modport dec (input cpuAddr, input ovlEnable, input ovlTarget,
        output ramHit, output ramIndex);
endinterface : fpnro_ovl_if

// [rtl/fpnro_rst_sync.sv]
// Two-flop synchroniser for the release of the active-low reset.
`timescale 1ns/10ps
module fpnro_rst_sync (
    input wire logic clk, // System clock.
    input wire logic rstN, // Asynchronous reset, active low.
    output logic rstSyncN // Reset with synchronised release.
);
    logic stage1_q;

    // Assert at once, release after two clock edges.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            stage1_q <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            rstSyncN <= stage1_q;
        end
    end
endmodule : fpnro_rst_sync

// [rtl/fpnro_overlay.sv]
// Address decoder that steers an overlaid flash block onto the RAM window.
`timescale 1ns/10ps
module fpnro_overlay
    import fpnro_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rstN, // Synchronised reset, active low.
    fpnro_ovl_if.dec ovl // Decode request and registered result.
);
    logic inRamWin;
    logic inFlashWin;
    logic [19:0] flashBase;

    // The target block sits at target times the window size.
    assign flashBase = {7'h00, ovl.ovlTarget, 10'h000};
    assign inRamWin = ovl.cpuAddr[19:FPNRO_WIN_BITS]
        == FPNRO_RAM_BASE[19:FPNRO_WIN_BITS];
    assign inFlashWin = ovl.ovlEnable
        && ovl.cpuAddr[19:FPNRO_WIN_BITS] == flashBase[19:FPNRO_WIN_BITS];

    // Both windows land on the same RAM word, registered.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ovl.ramHit <= 1'b0;
            ovl.ramIndex <= 10'h000;
        end else begin
            ovl.ramHit <= inRamWin || inFlashWin;
            ovl.ramIndex <= ovl.cpuAddr[FPNRO_WIN_BITS-1:0];
        end
    end
endmodule : fpnro_overlay

// [rtl/fpnro_top.sv]
// Flash program and erase protection, interrupt gate and RAM overlay.
`timescale 1ns/10ps
module fpnro_top
    import fpnro_pkg::*;
(
    input wire logic sys_clk, // System clock, 20 MHz.
    input wire logic nrst, // External reset pin, active low.
    // ==========================================================
    // Register bus slave.
    input wire logic [4:0] avsAddress, // Byte address.
    input wire logic avsRead, // Read request.
    input wire logic avsWrite, // Write request.
    input wire logic [31:0] avsWritedata, // Write data.
    input wire logic [3:0] avsByteenable, // Byte lanes.
    output logic [31:0] avsReaddata, // Read data, registered.
    output logic avsWaitrequest, // Stall, combinational.
    // ==========================================================
    // System status inputs.
    input wire logic writeEnablePin, // Flash write-enable pin, high.
    input wire logic onBoardMode, // On-board programming mode.
    input wire logic bootMode, // Boot mode selected.
    input wire logic bootBranch, // Pulse: execution entered RAM boot.
    input wire logic wdtReset, // Pulse: watchdog reset.
    input wire logic softStandby, // Software standby level.
    input wire logic hwStandby, // Hardware standby level.
    input wire logic faultDetect, // Pulse: malfunction detected.
    input wire logic nmiIn, // Non-maskable interrupt request.
    input wire logic [19:0] cpuAddr, // CPU address for overlay.
    // ==========================================================
    // Outputs.
    output logic nmiOut, // Gated interrupt, registered.
    output logic progMode, // Program mode active.
    output logic eraseMode, // Erase mode active.
    output logic progVerifyMode, // Program-verify mode active.
    output logic eraseVerifyMode, // Erase-verify mode active.
    output logic [7:0] eraseBlockEn, // Blocks being erased.
    output logic ramHit, // Access reaches the RAM window.
    output logic [9:0] ramIndex // Word within the RAM window.
);
    // ==========================================================
    // Reset synchroniser.
    logic rstN;

    fpnro_rst_sync fpnro_rst_sync_inst (
        .clk(sys_clk),
        .rstN(nrst),
        .rstSyncN(rstN)
    );

    // ==========================================================
    // Register state.
    logic [7:0] flashCtrl_q;
    logic [7:0] blockSel_q;
    logic [7:0] ramOverlay_q;
    logic faultFlag_q;
    logic bootBranched_q;
    fpnro_mode_t mode_q;
    fpnro_mode_t mode_d;
    logic ack_q;

    // Decoded control bits.
    logic progGo;
    logic eraseGo;
    logic progVerifySel;
    logic eraseVerifySel;
    logic swWriteEnable;
    logic emulationLock;
    logic [2:0] ovlTarget;

    assign progGo = flashCtrl_q[FPNRO_CTRL_PGO];
    assign eraseGo = flashCtrl_q[FPNRO_CTRL_EGO];
    assign progVerifySel = flashCtrl_q[FPNRO_CTRL_PVER];
    assign eraseVerifySel = flashCtrl_q[FPNRO_CTRL_EVER];
    assign swWriteEnable = flashCtrl_q[FPNRO_CTRL_SWEN];
    assign emulationLock = ramOverlay_q[FPNRO_OVL_LOCK];
    assign ovlTarget = ramOverlay_q[FPNRO_OVL_TGT_LSB +: 3];

    // ==========================================================
    // Bus handshake: every access waits exactly one cycle.
    logic busReq;
    logic busDo;
    logic wrLane0;

    assign busReq = avsRead || avsWrite;
    assign avsWaitrequest = busReq && !ack_q;
    assign busDo = busReq && ack_q;
    assign wrLane0 = busDo && avsWrite && avsByteenable[0];

    // The acknowledge toggles so that back-to-back requests each wait.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq && !ack_q;
        end
    end

    // ==========================================================
    // Initialisation of the control and block select registers.
    // Watchdog reset, either standby and the pin going low all clear
    // them, which drops any go bit and so leaves flash protected.
    logic regInit;

    assign regInit = wdtReset || softStandby || hwStandby
        || !writeEnablePin;

    // Control register: writable even under fault.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            flashCtrl_q <= FPNRO_CTRL_RST;
        end else if (regInit) begin
            flashCtrl_q <= FPNRO_CTRL_RST;
        end else if (wrLane0 && avsAddress == FPNRO_OFS_CTRL) begin
            flashCtrl_q <= {3'h0, avsWritedata[4:0]};
        end
    end

    // Block select register: writable even under fault.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            blockSel_q <= FPNRO_BSEL_RST;
        end else if (regInit) begin
            blockSel_q <= FPNRO_BSEL_RST;
        end else if (wrLane0 && avsAddress == FPNRO_OFS_BSEL) begin
            blockSel_q <= avsWritedata[7:0];
        end
    end

    // Overlay control: lock bit and three-bit target field.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ramOverlay_q <= FPNRO_OVL_RST;
        end else if (wrLane0 && avsAddress == FPNRO_OFS_OVL) begin
            ramOverlay_q <= {4'h0, avsWritedata[3:0]};
        end
    end

    // ==========================================================
    // Fault flag: set only by a malfunction while programming or
    // erasing; cleared only by the reset pin, watchdog reset or
    // hardware standby. Software writes cannot touch it.
    logic faultEvent;

    assign faultEvent = faultDetect
        && (mode_q == FPNRO_PROG || mode_q == FPNRO_ERASE);

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            faultFlag_q <= 1'b0;
        end else if (wdtReset || hwStandby) begin
            faultFlag_q <= 1'b0;
        end else if (faultEvent) begin
            faultFlag_q <= 1'b1;
        end
    end

    // ==========================================================
    // Boot branch: marks that execution has reached RAM boot code.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            bootBranched_q <= 1'b0;
        end else if (wdtReset || hwStandby) begin
            bootBranched_q <= 1'b0;
        end else if (bootBranch) begin
            bootBranched_q <= 1'b1;
        end
    end

    // ==========================================================
    // Protection terms.
    logic hwAllow;
    logic progAllowed;
    logic eraseAllowed;
    logic verifyAllowed;

    // Hardware gate: pin high and software enable set.
    assign hwAllow = writeEnablePin && swWriteEnable;
    // Programming is not blocked by block select, only by the hardware gate, lock and fault.
    assign progAllowed = progGo && hwAllow && !emulationLock
        && !faultFlag_q && !faultEvent;
    // Erasing also needs a selected block.
    assign eraseAllowed = eraseGo && hwAllow && !emulationLock
        && !faultFlag_q && !faultEvent
        && (blockSel_q != FPNRO_BSEL_RST);
    // Verify ignores lock, block select and fault.
    assign verifyAllowed = hwAllow;

    // ==========================================================
    // Mode selection. Program has priority over erase, and verify is
    // entered only when no go bit is set. A fault aborts at once.
    always_comb begin
        mode_d = FPNRO_IDLE;
        if (progAllowed) begin
            mode_d = FPNRO_PROG;
        end else if (eraseAllowed && !progGo) begin
            mode_d = FPNRO_ERASE;
        end else if (!progGo && !eraseGo && verifyAllowed) begin
            if (progVerifySel) begin
                mode_d = FPNRO_PVERIFY;
            end else if (eraseVerifySel) begin
                mode_d = FPNRO_EVERIFY;
            end
        end
    end

    // Mode register; the fault abort is folded into mode_d.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            mode_q <= FPNRO_IDLE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Mode outputs decoded from the one-hot state.
    always_comb begin
        progMode = 1'b0;
        eraseMode = 1'b0;
        progVerifyMode = 1'b0;
        eraseVerifyMode = 1'b0;
        unique case (mode_q)
            FPNRO_IDLE: begin
            end
            FPNRO_PROG: begin
                progMode = 1'b1;
            end
            FPNRO_ERASE: begin
                eraseMode = 1'b1;
            end
            FPNRO_PVERIFY: begin
                progVerifyMode = 1'b1;
            end
            FPNRO_EVERIFY: begin
                eraseVerifyMode = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // Erase strobes reach only the selected blocks in erase mode.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            eraseBlockEn <= 8'h00;
        end else if (mode_d == FPNRO_ERASE) begin
            eraseBlockEn <= blockSel_q;
        end else begin
            eraseBlockEn <= 8'h00;
        end
    end

    // ==========================================================
    // Non-maskable interrupt gate, only in on-board programming mode.
    logic goHeld;
    logic bootBlock;
    logic nmiBlock;

    // Go bits block only while the pin is high and software enable set.
    assign goHeld = (progGo || eraseGo) && hwAllow;
    assign bootBlock = bootMode && !bootBranched_q;
    assign nmiBlock = onBoardMode && !softStandby && !hwStandby
        && (goHeld || faultFlag_q || bootBlock);

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            nmiOut <= 1'b0;
        end else begin
            nmiOut <= nmiIn && !nmiBlock;
        end
    end

    // ==========================================================
    // RAM overlay decode. The lock bit also switches the window on,
    // and RAM writes through it stay accepted under emulation lock.
    fpnro_ovl_if uOvlIf ();

    assign uOvlIf.cpuAddr = cpuAddr;
    assign uOvlIf.ovlEnable = emulationLock;
    assign uOvlIf.ovlTarget = ovlTarget;
    assign ramHit = uOvlIf.ramHit;
    assign ramIndex = uOvlIf.ramIndex;

    fpnro_overlay fpnro_overlay_inst (
        .clk(sys_clk),
        .rstN(rstN),
        .ovl(uOvlIf.dec)
    );

    // ==========================================================
    // Read data: status shows fault, mode and gate state.
    logic [7:0] statusWord;
    logic [7:0] readMux;

    assign statusWord = {faultFlag_q, 1'b0, bootBranched_q, nmiBlock,
        mode_q[4], mode_q[3], mode_q[2], mode_q[1]};

    // Unmapped addresses read as zero.
    always_comb begin
        readMux = 8'h00;
        unique case (avsAddress)
            FPNRO_OFS_CTRL: begin
                readMux = flashCtrl_q;
            end
            FPNRO_OFS_BSEL: begin
                readMux = blockSel_q;
            end
            FPNRO_OFS_OVL: begin
                readMux = ramOverlay_q;
            end
            FPNRO_OFS_STAT: begin
                readMux = statusWord;
            end
            default: begin
                readMux = 8'h00;
            end
        endcase
    end

    // Read data is captured in the wait cycle and stands at the
    // edge where waitrequest is low.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            avsReaddata <= 32'h0000_0000;
        end else if (avsRead && !ack_q) begin
            avsReaddata <= {24'h000000, readMux};
        end
    end

endmodule : fpnro_top

// [testbench/fpnro_top_props.sv]
// Port-level checks for the flash protection block.
`timescale 1ns/10ps
module fpnro_top_props (
    input wire logic sys_clk, // Clock.
    input wire logic nrst, // Reset, active low.
    input wire logic avsRead, // Read request.
    input wire logic avsWrite, // Write request.
    input wire logic avsWaitrequest, // Stall.
    input wire logic onBoardMode, // On-board mode.
    input wire logic writeEnablePin, // Write-enable pin.
    input wire logic softStandby, // Software standby.
    input wire logic hwStandby, // Hardware standby.
    input wire logic wdtReset, // Watchdog reset.
    input wire logic faultDetect, // Fault pulse.
    input wire logic nmiIn, // Raw interrupt.
    input wire logic nmiOut, // Gated interrupt.
    input wire logic progMode, // Program mode.
    input wire logic eraseMode, // Erase mode.
    input wire logic progVerifyMode, // Program verify.
    input wire logic eraseVerifyMode, // Erase verify.
    input wire logic [19:0] cpuAddr, // CPU address.
    input wire logic ramHit, // Window hit.
    input wire logic [9:0] ramIndex // Window index.
);
    logic [1:0] rstCnt;
    logic live;
    logic busy;
    // Counts edges after reset so the synchroniser delay is skipped.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstCnt <= 2'h0;
        end else if (rstCnt != 2'h3) begin
            rstCnt <= rstCnt + 2'h1;
        end
    end
    assign live = (rstCnt == 2'h3);
    assign busy = progMode | eraseMode;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Sequences and properties.
    sequence s_oneWait;
        avsWaitrequest ##1 !avsWaitrequest;
    endsequence
    sequence s_idle3;
        (!progMode && !eraseMode)[*3];
    endsequence
    property p_wait;
        live && $rose(avsRead | avsWrite) |-> s_oneWait;
    endproperty
    property p_abort;
        live && faultDetect && busy |=> s_idle3;
    endproperty
    property p_nmiPass;
        live && !onBoardMode |=> nmiOut == $past(nmiIn);
    endproperty
    property p_nmiStby;
        live && (softStandby || hwStandby) |=> nmiOut == $past(nmiIn);
    endproperty
    property p_nmiBlock;
        live && busy && $past(onBoardMode) && !$past(softStandby)
            && !$past(hwStandby) |-> !nmiOut;
    endproperty
    property p_oneMode;
        live |-> $onehot0({progMode, eraseMode, progVerifyMode,
            eraseVerifyMode});
    endproperty
    property p_init;
        live && (wdtReset || softStandby || hwStandby || !writeEnablePin)
            |-> ##2 !(busy || progVerifyMode || eraseVerifyMode);
    endproperty
    property p_win;
        live && cpuAddr[19:10] == 10'h3fe
            |=> ramHit && ramIndex == $past(cpuAddr[9:0]);
    endproperty
    a_wait: assert property (p_wait) else $error("bad wait count");
    a_abort: assert property (p_abort) else $error("no abort");
    a_nmiPass: assert property (p_nmiPass) else $error("nmi gated");
    a_nmiStby: assert property (p_nmiStby) else $error("nmi held");
    a_nmiBlock: assert property (p_nmiBlock) else $error("nmi leak");
    a_oneMode: assert property (p_oneMode) else $error("two modes");
    a_init: assert property (p_init) else $error("no init");
    a_win: assert property (p_win) else $error("window miss");
endmodule : fpnro_top_props

bind fpnro_top fpnro_top_props fpnro_top_props_inst (
    .sys_clk(sys_clk), .nrst(nrst), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
    .onBoardMode(onBoardMode), .writeEnablePin(writeEnablePin),
    .softStandby(softStandby), .hwStandby(hwStandby),
    .wdtReset(wdtReset), .faultDetect(faultDetect), .nmiIn(nmiIn),
    .nmiOut(nmiOut), .progMode(progMode), .eraseMode(eraseMode),
    .progVerifyMode(progVerifyMode), .eraseVerifyMode(eraseVerifyMode),
    .cpuAddr(cpuAddr), .ramHit(ramHit), .ramIndex(ramIndex));

// [testbench/fpnro_bench.sv]
// Self-checking bench for the flash protection block.
`timescale 1ns/10ps
module fpnro_bench
    import fpnro_pkg::*;
;
    localparam logic [7:0] SW = 8'h10;
    localparam logic [7:0] PG = 8'h01;
    localparam logic [7:0] EG = 8'h02;
    localparam logic [7:0] PV = 8'h04;
    localparam logic [7:0] EV = 8'h08;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic writeEnablePin = 1'b1;
    logic onBoardMode = 1'b1;
    logic bootMode = 1'b0;
    logic bootBranch = 1'b0;
    logic wdtReset = 1'b0;
    logic softStandby = 1'b0;
    logic hwStandby = 1'b0;
    logic faultDetect = 1'b0;
    logic nmiIn = 1'b1;
    logic [19:0] cpuAddr = 20'h40000;
    logic nmiOut, progMode, eraseMode, progVerifyMode, eraseVerifyMode;
    logic ramHit;
    logic [9:0] ramIndex;
    logic [7:0] eraseBlockEn;
    int errorCnt = 0;
    int numChecks = 0;

    // Clock at 20 MHz.
    always #25 sys_clk = !sys_clk;

    fpnro_top fpnro_top_inst (.sys_clk(sys_clk), .nrst(nrst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(4'hf),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .writeEnablePin(writeEnablePin), .onBoardMode(onBoardMode),
        .bootMode(bootMode), .bootBranch(bootBranch), .wdtReset(wdtReset),
        .softStandby(softStandby), .hwStandby(hwStandby),
        .faultDetect(faultDetect), .nmiIn(nmiIn), .cpuAddr(cpuAddr),
        .nmiOut(nmiOut), .progMode(progMode), .eraseMode(eraseMode),
        .progVerifyMode(progVerifyMode), .eraseVerifyMode(eraseVerifyMode),
        .eraseBlockEn(eraseBlockEn), .ramHit(ramHit), .ramIndex(ramIndex));

    // ==========================================================
    // Shared tasks.
    task automatic wrapUp;
        $display("Checks %0d, errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrapUp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus cycle; the request is held until the rising edge at which
    // waitrequest is seen low, and read data is taken at that edge.
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= {24'h0, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge sys_clk);
        while (avsWaitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                errorCnt++;
                wrapUp();
            end
            @(posedge sys_clk);
        end
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask : rd

    task automatic lookPins(input logic [8:0] e);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({23'h0, eraseBlockEn, nmiOut}, {23'h0, e});
        @(posedge sys_clk);
    endtask : lookPins

    task automatic lookRam(input logic [10:0] e);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({21'h0, ramHit, ramIndex}, {21'h0, e});
        @(posedge sys_clk);
    endtask : lookRam

    task automatic pulseFault;
        faultDetect <= 1'b1;
        @(posedge sys_clk);
        faultDetect <= 1'b0;
    endtask : pulseFault

    task automatic doReset;
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : doReset

    // ==========================================================
    // Scenarios.
    task automatic tReset;
        for (int i = 0; i < 4; i++) begin
            rd(5'(4 * i), 8'h00);
        end
        wr(5'h10, 8'hff);
        rd(5'h10, 8'h00);
    endtask : tReset

    task automatic tProg;
        wr(FPNRO_OFS_CTRL, SW | PG);
        rd(FPNRO_OFS_STAT, 8'h11);
        lookPins(9'h000);
        writeEnablePin <= 1'b0;
        @(posedge sys_clk);
        writeEnablePin <= 1'b1;
        rd(FPNRO_OFS_CTRL, 8'h00);
        lookPins(9'h001);
    endtask : tProg

    task automatic tLock;
        wr(FPNRO_OFS_OVL, 8'h01);
        wr(FPNRO_OFS_CTRL, SW | PG);
        rd(FPNRO_OFS_STAT, 8'h10);
        wr(FPNRO_OFS_CTRL, SW | PV);
        rd(FPNRO_OFS_STAT, 8'h04);
        wr(FPNRO_OFS_OVL, 8'h00);
    endtask : tLock

    task automatic tBsel;
        wr(FPNRO_OFS_CTRL, SW | EG);
        rd(FPNRO_OFS_STAT, 8'h10);
        wr(FPNRO_OFS_BSEL, 8'h04);
        rd(FPNRO_OFS_STAT, 8'h12);
        lookPins({8'h04, 1'b0});
        wr(FPNRO_OFS_CTRL, SW | PG);
        rd(FPNRO_OFS_STAT, 8'h11);
        wr(FPNRO_OFS_CTRL, SW | EV);
        rd(FPNRO_OFS_STAT, 8'h08);
        wr(FPNRO_OFS_BSEL, 8'h00);
    endtask : tBsel

    task automatic tFault;
        wr(FPNRO_OFS_CTRL, SW | PG);
        pulseFault();
        rd(FPNRO_OFS_STAT, 8'h90);
        rd(FPNRO_OFS_CTRL, SW | PG);
        wr(FPNRO_OFS_CTRL, SW | PV);
        rd(FPNRO_OFS_STAT, 8'h94);
        wr(FPNRO_OFS_CTRL, SW | PG);
        rd(FPNRO_OFS_STAT, 8'h90);
        softStandby <= 1'b1;
        repeat (2) @(posedge sys_clk);
        softStandby <= 1'b0;
        rd(FPNRO_OFS_CTRL, 8'h00);
        rd(FPNRO_OFS_STAT, 8'h90);
        wdtReset <= 1'b1;
        @(posedge sys_clk);
        wdtReset <= 1'b0;
        rd(FPNRO_OFS_STAT, 8'h00);
        pulseFault();
        rd(FPNRO_OFS_STAT, 8'h00);
    endtask : tFault

    task automatic tNmiMode;
        onBoardMode <= 1'b0;
        wr(FPNRO_OFS_CTRL, SW | PG);
        lookPins(9'h001);
        wr(FPNRO_OFS_CTRL, 8'h00);
        onBoardMode <= 1'b1;
    endtask : tNmiMode

    task automatic tOverlay;
        cpuAddr <= 20'hff923;
        lookRam({1'b1, 10'h123});
        for (int t = 0; t < 8; t++) begin
            wr(FPNRO_OFS_OVL, {4'h0, 3'(t), 1'b1});
            cpuAddr <= {7'h0, 3'(t), 10'h155};
            lookRam({1'b1, 10'h155});
        end
        wr(FPNRO_OFS_OVL, 8'h00);
        lookRam({1'b0, 10'h155});
        cpuAddr <= 20'h40000;
    endtask : tOverlay

    task automatic tBoot;
        bootMode <= 1'b1;
        doReset();
        rd(FPNRO_OFS_STAT, 8'h10);
        bootBranch <= 1'b1;
        @(posedge sys_clk);
        bootBranch <= 1'b0;
        rd(FPNRO_OFS_STAT, 8'h20);
        wr(FPNRO_OFS_CTRL, SW | PG);
        rd(FPNRO_OFS_STAT, 8'h31);
    endtask : tBoot

    // Main sequence.
    initial begin
        doReset();
        tReset();
        tProg();
        tLock();
        tBsel();
        tFault();
        tNmiMode();
        tOverlay();
        tBoot();
        wrapUp();
    end
endmodule : fpnro_bench
